// *** src/pmc_params.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
// ****************************************
// register offsets (word index)
// ****************************************
`define PMC_OFS_STAT      4'h0
`define PMC_OFS_PINS      4'h1
// ****************************************
// status/arbitration fields
// ****************************************
`define PMC_BIT_BUSY      15
`define PMC_BIT_ERR       13
`define PMC_BIT_TMO       12
`define PMC_BIT_AREQ      11
`define PMC_BIT_OWNER     10
`define PMC_STAT_RESET    16'h0400
// writable: owner select and the whole eight-bit reserved-space field
`define PMC_STAT_WMASK    16'h03FF
// ****************************************
// pin enable fields
// ****************************************
`define PMC_BIT_WREN      15
`define PMC_BIT_RDEN      14
`define PMC_BIT_BE1EN     13
`define PMC_BIT_BE0EN     12
`define PMC_PINS_WMASK    16'hF77F
`define PMC_PINS_RESET    16'h0000
// ****************************************
// timing: instruction cycle is two clocks
// ****************************************
`define PMC_TCY_NS        40
`define PMC_CLK_NS        20
`define PMC_HALF_TCY      (`PMC_TCY_NS / 2 / `PMC_CLK_NS)
`define PMC_TOP_DEFAULT   24'hFFFFFF
`endif

// *** src/pmc_pkg.sv ***
// types for the parallel master port control/status block
`default_nettype none
package pmc_pkg;
  // register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pmc_bus_t;
  // transaction status events from the port engine
  typedef struct packed {
    logic busy;
    logic err;
    logic tmo;
  } pmc_evt_t;
  // latch strobe sequencer
  typedef enum logic [1:0] {
    PMC_IDLE  = 2'b00,
    PMC_HOLD  = 2'b01
  } pmc_state_t;
endpackage
`default_nettype wire

// *** src/pmc_ctrl.sv ***
// control, status, arbitration and pin-enable logic of the master port
//
// Design decisions made here: the address map and strobed register access.
`include "pmc_params.svh"
`default_nettype none
// How it works
// R1: illegal access sets sticky error, software clears
// R2: timeout sets sticky flag, software clears
// R3: request bit mirrors alternate master request
// R4: owner bit one for CPU, resets one
// R5: zero reserved field means top FFFFFF
// R6: strobe pins driven only when enabled
// R7: byte lane pins driven only when enabled
// R8: latch strobe stretched by coded wait states
// R9: busy follows transaction in progress
// R10: owner select routes pins, zero is CPU; here the select only goes out on port_owner_select, no pin is routed by it
module pmc_ctrl (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // register port
  input  wire pmc_pkg::pmc_bus_t bus,
  output logic [15:0]            rdata,
  // port engine status (same clock) and the alternate master request pin (asynchronous, two flops)
  input  wire pmc_pkg::pmc_evt_t evt,
  input  wire logic              alt_req_pin,
  // strobes and lanes from the engine
  input  wire logic              read_strobe_in,
  input  wire logic              write_strobe_in,
  input  wire logic [1:0]        lane_in,
  input  wire logic              latch_start,
  // pins
  output logic                   read_strobe_out,
  output logic                   read_strobe_oe,
  output logic                   write_strobe_out,
  output logic                   write_strobe_oe,
  output logic                   upper_lane_enable_out,
  output logic                   upper_lane_oe,
  output logic                   lower_lane_enable_out,
  output logic                   lower_lane_oe,
  output logic                   latch_strobe,
  output logic [23:0]            reserved_space_top,
  output logic                   current_port_owner,
  output logic [1:0]             port_owner_select
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] stat_reg, stat_next;     // status/arbitration
  logic [15:0] pins_reg, pins_next;     // strobe/pin enables
  logic        areq_s1_reg, areq_s2_reg; // request synchroniser
  logic [15:0] rdata_reg, rdata_next;   // read data, one cycle late
  pmc_pkg::pmc_state_t st_reg, st_next; // latch sequencer state
  logic [3:0]  cnt_reg, cnt_next;       // latch half-cycle counter
  logic [3:0]  wait_halves;             // selected latch length

  // register next values; set beats a same-cycle clear
  always_comb begin
    stat_next = stat_reg;
    pins_next = pins_reg;
    rdata_next = 16'h0000;
    // read-only bits keep their value; busy, request, owner refresh below
    if (bus.wr && bus.addr == `PMC_OFS_STAT) begin
      stat_next = (stat_reg & ~`PMC_STAT_WMASK) |
                  (bus.wdata & `PMC_STAT_WMASK);
      // error/timeout: writing zero clears
      stat_next[`PMC_BIT_ERR] = stat_reg[`PMC_BIT_ERR] &
                                bus.wdata[`PMC_BIT_ERR];
      stat_next[`PMC_BIT_TMO] = stat_reg[`PMC_BIT_TMO] &
                                bus.wdata[`PMC_BIT_TMO];
    end
    if (bus.wr && bus.addr == `PMC_OFS_PINS) begin
      pins_next = bus.wdata & `PMC_PINS_WMASK;
    end
    if (evt.err) begin
      stat_next[`PMC_BIT_ERR] = 1'b1; // R1
    end
    if (evt.tmo) begin
      stat_next[`PMC_BIT_TMO] = 1'b1; // R2
    end
    stat_next[`PMC_BIT_BUSY]  = evt.busy;    // R9
    stat_next[`PMC_BIT_AREQ]  = areq_s2_reg; // R3
    // cpu owns the port while select is zero
    // uses the select written this cycle, so owner never lags it
    stat_next[`PMC_BIT_OWNER] = (stat_next[9:8] == 2'b00); // R4 R10
    if (bus.rd) begin
      unique case (bus.addr)
        `PMC_OFS_STAT: rdata_next = stat_reg;
        `PMC_OFS_PINS: rdata_next = pins_reg;
        default:       rdata_next = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // register update
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stat_reg    <= `PMC_STAT_RESET;
      pins_reg    <= `PMC_PINS_RESET;
      rdata_reg   <= 16'h0000;
      areq_s1_reg <= 1'b0;
      areq_s2_reg <= 1'b0;
    end else begin
      stat_reg    <= stat_next;
      pins_reg    <= pins_next;
      rdata_reg   <= rdata_next;
      areq_s1_reg <= alt_req_pin; // pin from outside: two flops
      areq_s2_reg <= areq_s1_reg;
    end
  end

  // ****************************************
  // latch strobe sequencer
  // ****************************************
  // length in clocks: main code gives n+1/2 cycles, extra adds 1 or 1/2
  assign wait_halves = 4'(({2'b00, pins_reg[10:9]} * 4'h2 + 4'h1 +
                        (pins_reg[8] ? 4'h2 : 4'h1)) * `PMC_HALF_TCY); // R8

  // sequencer next state
  // a start pulse while the strobe runs is dropped, not queued
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      pmc_pkg::PMC_IDLE: begin
        if (latch_start) begin
          st_next  = pmc_pkg::PMC_HOLD;
          cnt_next = wait_halves - 4'h1;
        end
      end
      pmc_pkg::PMC_HOLD: begin
        if (cnt_reg == 4'h0) begin
          st_next = pmc_pkg::PMC_IDLE; // R8
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: st_next = pmc_pkg::PMC_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_reg  <= pmc_pkg::PMC_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata              = rdata_reg;
  assign latch_strobe       = (st_reg == pmc_pkg::PMC_HOLD);
  // zero field means the whole 24-bit space
  assign reserved_space_top = (stat_reg[7:0] == 8'h00) ?
                              `PMC_TOP_DEFAULT :
                              {stat_reg[7:0], 16'hFFFF}; // R5
  assign current_port_owner = stat_reg[`PMC_BIT_OWNER];
  assign port_owner_select  = stat_reg[9:8]; // R10
  // strobe pins: the engine's level passes only while enabled
  assign read_strobe_oe     = pins_reg[`PMC_BIT_RDEN];  // R6
  assign write_strobe_oe    = pins_reg[`PMC_BIT_WREN];  // R6
  assign read_strobe_out    = read_strobe_oe & read_strobe_in;
  assign write_strobe_out   = write_strobe_oe & write_strobe_in;
  // per-lane gate; a cleared enable releases that lane's pin
  logic [1:0] lane_oe;  // lane pin enables, upper lane in bit 1
  logic [1:0] lane_out; // gated lane strobes
  assign lane_oe = {pins_reg[`PMC_BIT_BE1EN],
                    pins_reg[`PMC_BIT_BE0EN]}; // R7
  for (genvar i = 0; i < 2; i++) begin : g_lane
    // the engine's lane only reaches an enabled pin
    assign lane_out[i] = lane_oe[i] & lane_in[i]; // R7
  end
  assign upper_lane_oe         = lane_oe[1];
  assign lower_lane_oe         = lane_oe[0];
  assign upper_lane_enable_out = lane_out[1];
  assign lower_lane_enable_out = lane_out[0];

  // ****************************************
  // checks
  // ****************************************
  a_err_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    evt.err |=> stat_reg[`PMC_BIT_ERR]) else $error("error flag not set");
  a_tmo_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
    evt.tmo |=> stat_reg[`PMC_BIT_TMO]) else $error("timeout flag not set");
  a_req_follow: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    stat_reg[`PMC_BIT_AREQ] == $past(alt_req_pin, 3))
    else $error("request bit lag wrong");
  a_owner_cpu: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
    current_port_owner == (port_owner_select == 2'b00))
    else $error("owner bit wrong");
  a_top_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
    stat_reg[7:0] == 8'h00 |-> reserved_space_top == 24'hFFFFFF)
    else $error("top address wrong");
  a_strobe_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    !read_strobe_oe |-> !read_strobe_out) else $error("read strobe leaked");
  a_lane_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
    !upper_lane_oe |-> !upper_lane_enable_out) else $error("lane leaked");
  a_latch_len: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
    (st_reg == pmc_pkg::PMC_IDLE && latch_start && pins_reg[10:8] == 3'b000)
    |=> latch_strobe [*2] ##1 !latch_strobe) else $error("latch length");
  a_busy_follow: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
    evt.busy |=> stat_reg[`PMC_BIT_BUSY]) else $error("busy not shown");
  a_busy_clear: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
    !evt.busy |=> !stat_reg[`PMC_BIT_BUSY]) else $error("busy stuck");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    bus.wr && bus.addr == `PMC_OFS_STAT && !bus.wdata[`PMC_BIT_ERR] &&
    !evt.err |=> !stat_reg[`PMC_BIT_ERR]) else $error("error flag kept");
  a_wr_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    !write_strobe_oe |-> !write_strobe_out) else $error("write leaked");
  a_lower_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
    !lower_lane_oe |-> !lower_lane_enable_out) else $error("lower leaked");
  // covers: new error, alternate owner, latch end, set racing clear
  c_err: cover property (@(posedge ref_clk) disable iff (!rst_b) evt.err);
  c_set_wins: cover property (@(posedge ref_clk) disable iff (!rst_b)
    evt.err && bus.wr && bus.addr == `PMC_OFS_STAT);
  c_alt: cover property (@(posedge ref_clk) disable iff (!rst_b)
    port_owner_select != 2'b00);
  c_latch: cover property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(latch_strobe));
endmodule
`default_nettype wire

// *** test/pmc_ext_dev.sv ***
// external peripheral model watching the write strobe pin
`default_nettype none
module pmc_ext_dev (
  // clock
  input  wire logic ref_clk,
  // pin and its driver enable
  input  wire logic wr_pin,
  input  wire logic wr_oe,
  // strobe cycles seen on a driven pin
  output int        hits
);
  timeunit 1ns;
  timeprecision 1ps;
  initial hits = 0;
  // an undriven pin is pulled low, so only driven cycles count
  always @(posedge ref_clk) begin
    if (wr_oe && wr_pin) begin
      hits <= hits + 1;
    end
  end
endmodule
`default_nettype wire

// *** test/test_pmc_ctrl.sv ***
// self-checking bench for the master port control block
`include "pmc_params.svh"
`default_nettype none
module test_pmc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, rs, ws, ls, rso, rse, wso, wse;
  logic uo, ue, lo, le, own;
  pmc_pkg::pmc_bus_t bus;
  pmc_pkg::pmc_evt_t evt;
  logic [1:0] lane, sel;
  logic [15:0] rdata;
  logic [23:0] top;
  logic areq, lst;
  int miscompares, tests_run, cyc, hits;
  pmc_ctrl pmc_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .evt(evt), .alt_req_pin(areq), .read_strobe_in(rs),
    .write_strobe_in(ws), .lane_in(lane), .latch_start(lst),
    .read_strobe_out(rso), .read_strobe_oe(rse), .write_strobe_out(wso),
    .write_strobe_oe(wse), .upper_lane_enable_out(uo), .upper_lane_oe(ue),
    .lower_lane_enable_out(lo), .lower_lane_oe(le), .latch_strobe(ls),
    .reserved_space_top(top), .current_port_owner(own),
    .port_owner_select(sel));
  pmc_ext_dev pmc_ext_dev_inst (.ref_clk(ref_clk), .wr_pin(wso),
    .wr_oe(wse), .hits(hits));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_regs();
    logic [15:0] d;
    rd(`PMC_OFS_STAT, d); chk(d, 16'h0400);
    chk({own, top}, 25'h1FFFFFF);
    rd(4'h2, d); chk(d, 16'h0000);
    wr(4'h3, 16'hFFFF); rd(`PMC_OFS_PINS, d); chk(d, 16'h0000);
    wr(`PMC_OFS_STAT, 16'hC112); rd(`PMC_OFS_STAT, d);
    chk(d, 16'h0112);
    chk({own, sel, top}, 27'h112FFFF);
    wr(`PMC_OFS_STAT, 16'h0000); #1 chk({own, top}, 25'h1FFFFFF);
    $display("test regs done");
  endtask
  task automatic t_flags();
    logic [15:0] d;
    @(posedge ref_clk) evt.err <= 1'b1;
    @(posedge ref_clk) evt.err <= 1'b0;
    rd(`PMC_OFS_STAT, d); chk(d, 16'h2400);
    @(posedge ref_clk) evt.tmo <= 1'b1;
    @(posedge ref_clk) evt <= '{busy: 1'b1, err: 1'b0, tmo: 1'b0};
    rd(`PMC_OFS_STAT, d); chk(d, 16'hB400);
    wr(`PMC_OFS_STAT, 16'h3400); rd(`PMC_OFS_STAT, d); chk(d, 16'hB400);
    @(posedge ref_clk) evt.busy <= 1'b0;
    wr(`PMC_OFS_STAT, 16'h0000); rd(`PMC_OFS_STAT, d); chk(d, 16'h0400);
    @(posedge ref_clk) areq <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`PMC_OFS_STAT, d); chk(d, 16'h0C00);
    @(posedge ref_clk) areq <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(`PMC_OFS_STAT, d); chk(d, 16'h0400);
    // a clearing write in the cycle of a new error must lose
    @(posedge ref_clk);
    bus <= '{addr: `PMC_OFS_STAT, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
    evt.err <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    evt.err <= 1'b0;
    rd(`PMC_OFS_STAT, d); chk(d, 16'h2400);
    wr(`PMC_OFS_STAT, 16'h0000);
    rd(`PMC_OFS_STAT, d); chk(d, 16'h0400);
    $display("test flags done");
  endtask
  task automatic t_pins();
    int h;
    @(posedge ref_clk);
    rs <= 1'b1; ws <= 1'b1; lane <= 2'b11;
    h = hits;
    wr(`PMC_OFS_PINS, 16'h0000);
    #1 chk({rso,rse,wso,wse,uo,ue,lo,le}, 0);
    chk(hits, h);
    wr(`PMC_OFS_PINS, 16'h4000); #1 chk({rso,rse,wso,wse}, 4'hC);
    wr(`PMC_OFS_PINS, 16'h1000); #1 chk({uo,ue,lo,le}, 4'h3);
    wr(`PMC_OFS_PINS, 16'hF000);
    #1 chk({rso,rse,wso,wse,uo,ue,lo,le}, 8'hFF);
    @(posedge ref_clk) #1 chk(hits, h + 1);
    @(posedge ref_clk);
    rs <= 1'b0; ws <= 1'b0; lane <= 2'b00;
    $display("test pins done");
  endtask
  task automatic t_latch();
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(`PMC_OFS_PINS, 16'(c) << 8);
      @(posedge ref_clk) lst <= 1'b1;
      @(posedge ref_clk) lst <= 1'b0;
      n = 0;
      #1 while (ls === 1'b1 && n < 40) begin
        n++;
        @(posedge ref_clk) #1;
      end
      chk(n, 2 * (c >> 1) + 1 + ((c & 1) ? 2 : 1));
    end
    $display("test latch done");
  endtask
  // mid-run reset during a running latch strobe
  task automatic t_reset();
    logic [15:0] d;
    wr(`PMC_OFS_PINS, 16'hF700);
    wr(`PMC_OFS_STAT, 16'h0312);
    @(posedge ref_clk) lst <= 1'b1;
    @(posedge ref_clk) lst <= 1'b0;
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk({ls, rse, wse, ue, le}, 0);
    rd(`PMC_OFS_STAT, d); chk(d, 16'h0400);
    chk({own, sel, top}, 27'h4FFFFFF);
    rd(`PMC_OFS_PINS, d); chk(d, 16'h0000);
    $display("test reset done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    miscompares = 0;
    tests_run = 0;
    cyc = 0;
    rst_b = 1'b0; bus = '0; evt = '0; areq = 1'b0;
    {rs, ws, lst} = 3'b000; lane = 2'b00;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs(); t_flags(); t_pins(); t_latch(); t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
